/* verilog/tic_defines.vh */
// Constants for the cycle, interrupt and timer control block
`ifndef TIC_DEFINES_VH
`define TIC_DEFINES_VH
`define TIC_OSC_DIV 2'h3
`define TIC_STATES_PER_MC 3'h5
`define TIC_PRESCALE_LAST 5'h1f
`define TIC_EVT_GAP 2'h2
`define TIC_EXT_VECTOR 12'h003
`define TIC_TMR_VECTOR 12'h007
`define TIC_PC_RST 12'h000
`define TIC_STATUS_RST 8'h08
`define TIC_STATUS_SP_LSB 0
`define TIC_STATUS_SP_MSB 2
`define TIC_STATUS_BANK_BIT 4
`define TIC_STATUS_F0_BIT 5
`define TIC_STROBE_CLKS 4'h9
`endif

/* verilog/tic_ctrl.v */
// Cycle timing, single-level interrupt, timer/event counter and strobed bus control
//
// Functional notes
// RULE_01: Bus output latched; input unlatched; eight lines together.
// RULE_02: Static input strobes read; static output strobes write.
// RULE_03: External write: data valid through write strobe rise.
// RULE_04: Responder holds read data until read strobe rises.
// RULE_05: Bus floats when no transfer is running.
// RULE_06: Branches test both test pins and interrupt pin.
// RULE_07: Low interrupt pin requests; sampled at address strobe.
// RULE_08: External accept: vector 3, push PC and status.
// RULE_09: One level; accept again at return's second cycle.
// RULE_10: Return restores, then rechecks requests for vectoring.
// RULE_11: External request wins over simultaneous timer request.
// RULE_12: Eight-bit up counter, loaded and read by software.
// RULE_13: Reset stops counter but keeps its value.
// RULE_14: Wrap from maximum sets overflow and timer request.
// RULE_15: Branch-on-overflow tests and clears the overflow flag.
// RULE_16: Timer accept branches to program address 7.
// RULE_17: Timer request waits during service; disable blocks it.
// RULE_18: Event mode counts pin pulses, one per three cycles.
// RULE_19: Timer mode counts address strobes divided by 32.
// RULE_20: State clock is oscillator over three, optional pin output.
// RULE_21: Five states per machine cycle, one address strobe.
// RULE_22: Reset clears PC, pointer, banks, enables, flags, bus.
`timescale 1ns/1ns
`include "tic_defines.vh"
module tic_ctrl (
  input wire clk_sys,
  input wire reset_n,
  input wire int_n_pin,
  input wire first_test_pin_in,
  input wire count_input_pin,
  input wire [7:0] bus_in,
  input wire [7:0] acc_in,
  input wire op_counter_load,
  input wire op_counter_read,
  input wire op_branch_on_overflow,
  input wire op_select_event_counting,
  input wire op_select_timer_counting,
  input wire op_stop_counter,
  input wire op_ext_irq_enable,
  input wire op_ext_irq_disable,
  input wire op_timer_irq_enable,
  input wire op_timer_irq_disable,
  input wire op_state_clock_pin_enable,
  input wire op_return_restore,
  input wire [15:0] restore_word,
  input wire op_pc_load,
  input wire [11:0] pc_load_value,
  input wire op_status_write,
  input wire [7:0] status_wr_data,
  input wire op_user_flag_one_write,
  input wire user_flag_one_value,
  input wire op_mem_bank_write,
  input wire mem_bank_value,
  input wire op_bus_static_output,
  input wire op_bus_static_input,
  input wire op_external_data_write,
  input wire op_external_data_read,
  output reg [7:0] bus_out_ff,
  output reg bus_oe_ff,
  output reg rd_n_ff,
  output reg wr_n_ff,
  output reg [7:0] bus_rd_data_ff,
  output reg bus_rd_valid_ff,
  output reg bus_busy_ff,
  output reg first_test_pin_out_ff,
  output reg first_test_pin_oe_ff,
  output reg state_clk_ff,
  output reg ale_ff,
  output reg test0_level_ff,
  output reg test1_level_ff,
  output reg int_level_ff,
  output reg overflow_taken_ff,
  output reg [7:0] counter_rd_data_ff,
  output reg [11:0] pc_ff,
  output reg [7:0] status_ff,
  output reg user_flag_one_ff,
  output reg mem_bank_ff,
  output reg stack_push_ff,
  output reg [15:0] stack_push_data_ff,
  output reg irq_vector_ff,
  output reg in_service_ff
);

  localparam MODE_STOP = 3'b001, MODE_TIMER = 3'b010, MODE_EVENT = 3'b100;
  localparam BUS_IDLE = 3'b001, BUS_STROBE = 3'b010, BUS_HOLD = 3'b100;

  // Stack pointer step, up on push and down on return
  function [2:0] sp_step;
    input [2:0] sp;
    input up;
    sp_step = up ? sp + 3'h1 : sp - 3'h1;
  endfunction

  reg [2:0] pin_s1_ff, pin_s2_ff, state_cnt_ff, mode_ff, bus_st_ff;
  reg [7:0] bus_s1_ff, bus_s2_ff, count_ff;
  reg [1:0] div3_ff, gap_ff;
  reg [4:0] presc_ff;
  reg [3:0] strobe_cnt_ff;
  reg ext_en_ff, tmr_en_ff, ret_pending_ff, ovf_ff, tmr_req_ff, t1_prev_ff, tclk_en_ff, bus_is_read_ff;

  wire state_tick = (div3_ff == `TIC_OSC_DIV - 2'h1);
  wire ale_tick = state_tick && (state_cnt_ff == `TIC_STATES_PER_MC - 3'h1);
  wire int_req = ~pin_s2_ff[0]; // [RULE_07]
  wire t1_now = pin_s2_ff[2];
  wire service_free = ~in_service_ff | ret_pending_ff;
  wire take_ext = ale_tick && service_free && ext_en_ff && int_req; // [RULE_07]
  wire take_tmr = ale_tick && service_free && tmr_en_ff && tmr_req_ff && ~take_ext;
  wire take_any = take_ext | take_tmr;
  wire presc_tick = ale_tick && (mode_ff == MODE_TIMER) && (presc_ff == `TIC_PRESCALE_LAST);
  wire evt_tick = ale_tick && (mode_ff == MODE_EVENT) && t1_prev_ff && ~t1_now && (gap_ff == 2'h0);
  wire count_inc = (presc_tick | evt_tick) && ~op_counter_load;
  wire count_wrap = count_inc && (count_ff == 8'hff);
  wire bus_start = (bus_st_ff == BUS_IDLE) &&
    (op_bus_static_output | op_bus_static_input | op_external_data_write | op_external_data_read);
  wire bus_read_op = op_bus_static_input | op_external_data_read;

  // Pin synchronisers
  always @(posedge clk_sys) begin
    pin_s1_ff <= {count_input_pin, first_test_pin_in, int_n_pin};
    pin_s2_ff <= pin_s1_ff;
    bus_s1_ff <= bus_in;
    bus_s2_ff <= bus_s1_ff;
  end

  // Counter value survives reset
  always @(posedge clk_sys) begin
    if (op_counter_load) begin
      count_ff <= acc_in; // [RULE_12]
    end else if (count_inc) begin
      count_ff <= count_ff + 8'h01; // [RULE_14]
    end
  end

  always @(posedge clk_sys) begin
    if (!reset_n) begin
      div3_ff <= 2'h0;
      state_cnt_ff <= 3'h0;
      state_clk_ff <= 1'b0;
      ale_ff <= 1'b0;
      tclk_en_ff <= 1'b0;
      first_test_pin_out_ff <= 1'b0;
      first_test_pin_oe_ff <= 1'b0;
      test0_level_ff <= 1'b0;
      test1_level_ff <= 1'b0;
      int_level_ff <= 1'b1;
    end else begin
      if (state_tick) begin
        div3_ff <= 2'h0; // [RULE_20]
        state_cnt_ff <= (state_cnt_ff == `TIC_STATES_PER_MC - 3'h1) ? 3'h0 : state_cnt_ff + 3'h1; // [RULE_21]
      end else begin
        div3_ff <= div3_ff + 2'h1;
      end
      state_clk_ff <= state_tick;
      ale_ff <= ale_tick; // [RULE_21]
      tclk_en_ff <= tclk_en_ff | op_state_clock_pin_enable; // [RULE_20]
      first_test_pin_out_ff <= tclk_en_ff & state_tick; // [RULE_20]
      first_test_pin_oe_ff <= tclk_en_ff;
      test0_level_ff <= pin_s2_ff[1]; // [RULE_06]
      test1_level_ff <= pin_s2_ff[2]; // [RULE_06]
      int_level_ff <= pin_s2_ff[0]; // [RULE_06]
    end
  end

  // Counter mode, prescaler, event detection, overflow
  always @(posedge clk_sys) begin
    if (!reset_n) begin
      mode_ff <= MODE_STOP; // [RULE_13]
      presc_ff <= 5'h00;
      t1_prev_ff <= 1'b0;
      gap_ff <= 2'h0;
      ovf_ff <= 1'b0; // [RULE_22]
      tmr_req_ff <= 1'b0;
      overflow_taken_ff <= 1'b0;
      counter_rd_data_ff <= 8'h00;
    end else begin
      if (op_stop_counter) begin
        mode_ff <= MODE_STOP;
      end else if (op_select_timer_counting) begin
        mode_ff <= MODE_TIMER; // [RULE_19]
        presc_ff <= 5'h00;
      end else if (op_select_event_counting) begin
        mode_ff <= MODE_EVENT; // [RULE_18]
      end
      if (ale_tick && !op_select_timer_counting) begin
        presc_ff <= presc_ff + 5'h01; // [RULE_19]
      end
      if (ale_tick) begin
        t1_prev_ff <= t1_now;
        if (evt_tick) begin
          gap_ff <= `TIC_EVT_GAP; // [RULE_18]
        end else if (gap_ff != 2'h0) begin
          gap_ff <= gap_ff - 2'h1;
        end
      end
      overflow_taken_ff <= op_branch_on_overflow ? ovf_ff : overflow_taken_ff; // [RULE_15]
      if (count_wrap) begin
        ovf_ff <= 1'b1; // [RULE_14]
      end else if (op_branch_on_overflow) begin
        ovf_ff <= 1'b0; // [RULE_15]
      end
      if (count_wrap) begin
        tmr_req_ff <= 1'b1; // [RULE_14]
      end else if (take_tmr) begin
        tmr_req_ff <= 1'b0; // [RULE_17]
      end
      counter_rd_data_ff <= op_counter_read ? count_ff : counter_rd_data_ff; // [RULE_12]
    end
  end

  // Interrupt acceptance, program counter and status word
  always @(posedge clk_sys) begin
    if (!reset_n) begin
      ext_en_ff <= 1'b0; // [RULE_22]
      tmr_en_ff <= 1'b0;
      in_service_ff <= 1'b0;
      ret_pending_ff <= 1'b0;
      pc_ff <= `TIC_PC_RST;
      status_ff <= `TIC_STATUS_RST;
      user_flag_one_ff <= 1'b0;
      mem_bank_ff <= 1'b0;
      stack_push_ff <= 1'b0;
      stack_push_data_ff <= 16'h0000;
      irq_vector_ff <= 1'b0;
    end else begin
      if (op_ext_irq_enable) begin
        ext_en_ff <= 1'b1;
      end else if (op_ext_irq_disable) begin
        ext_en_ff <= 1'b0;
      end
      if (op_timer_irq_enable) begin
        tmr_en_ff <= 1'b1;
      end else if (op_timer_irq_disable) begin
        tmr_en_ff <= 1'b0; // [RULE_17]
      end
      user_flag_one_ff <= op_user_flag_one_write ? user_flag_one_value : user_flag_one_ff;
      mem_bank_ff <= op_mem_bank_write ? mem_bank_value : mem_bank_ff;
      stack_push_ff <= take_any;
      irq_vector_ff <= take_any;
      if (take_any) begin
        stack_push_data_ff <= {status_ff[7:4], pc_ff}; // [RULE_08]
        status_ff[`TIC_STATUS_SP_MSB:`TIC_STATUS_SP_LSB] <=
          sp_step(status_ff[`TIC_STATUS_SP_MSB:`TIC_STATUS_SP_LSB], 1'b1);
        in_service_ff <= 1'b1; // [RULE_09]
        ret_pending_ff <= 1'b0;
        if (take_ext) begin
          pc_ff <= `TIC_EXT_VECTOR; // [RULE_08] [RULE_11]
        end else begin
          pc_ff <= `TIC_TMR_VECTOR; // [RULE_16] [RULE_17]
        end
      end else if (op_return_restore) begin
        pc_ff <= restore_word[11:0]; // [RULE_10]
        status_ff[7:4] <= restore_word[15:12];
        status_ff[`TIC_STATUS_SP_MSB:`TIC_STATUS_SP_LSB] <=
          sp_step(status_ff[`TIC_STATUS_SP_MSB:`TIC_STATUS_SP_LSB], 1'b0);
        ret_pending_ff <= 1'b1;
      end else begin
        if (ret_pending_ff && ale_tick) begin
          in_service_ff <= 1'b0; // [RULE_09] [RULE_10]
          ret_pending_ff <= 1'b0;
        end
        if (op_pc_load) begin
          pc_ff <= pc_load_value;
        end
        if (op_status_write) begin
          status_ff <= status_wr_data | `TIC_STATUS_RST;
        end
      end
    end
  end

  // Strobed data bus
  always @(posedge clk_sys) begin
    if (!reset_n) begin
      bus_st_ff <= BUS_IDLE;
      bus_out_ff <= 8'h00;
      bus_oe_ff <= 1'b0; // [RULE_05]
      rd_n_ff <= 1'b1;
      wr_n_ff <= 1'b1;
      bus_is_read_ff <= 1'b0;
      strobe_cnt_ff <= 4'h0;
      bus_rd_data_ff <= 8'h00;
      bus_rd_valid_ff <= 1'b0;
      bus_busy_ff <= 1'b0;
    end else begin
      bus_rd_valid_ff <= 1'b0;
      case (bus_st_ff)
        BUS_IDLE: begin
          bus_busy_ff <= bus_start;
          if (bus_start) begin
            bus_st_ff <= BUS_STROBE;
            strobe_cnt_ff <= `TIC_STROBE_CLKS;
            bus_is_read_ff <= bus_read_op;
            if (bus_read_op) begin
              rd_n_ff <= 1'b0; // [RULE_02]
            end else begin
              bus_out_ff <= acc_in; // [RULE_01]
              bus_oe_ff <= 1'b1; // [RULE_01]
              wr_n_ff <= 1'b0; // [RULE_02] [RULE_03]
            end
          end
        end
        BUS_STROBE: begin
          if (strobe_cnt_ff == 4'h1) begin
            bus_st_ff <= BUS_HOLD;
            rd_n_ff <= 1'b1;
            wr_n_ff <= 1'b1;
            if (bus_is_read_ff) begin
              bus_rd_data_ff <= bus_s2_ff; // [RULE_04]
              bus_rd_valid_ff <= 1'b1;
            end
          end
          strobe_cnt_ff <= strobe_cnt_ff - 4'h1;
        end
        BUS_HOLD: begin
          bus_oe_ff <= 1'b0; // [RULE_03] [RULE_05]
          bus_busy_ff <= 1'b0;
          bus_st_ff <= BUS_IDLE;
        end
        default: begin
          bus_st_ff <= BUS_IDLE;
          bus_oe_ff <= 1'b0;
          rd_n_ff <= 1'b1;
          wr_n_ff <= 1'b1;
        end
      endcase
    end
  end

endmodule

/* verification/tic_ctrl_asserts.sv */
// Port-level checks for the cycle, interrupt and timer block
`timescale 1ns/1ns
module tic_ctrl_asserts (
  input wire clk_sys,
  input wire reset_n,
  input wire op_return_restore,
  input wire [7:0] bus_out_ff,
  input wire bus_oe_ff,
  input wire rd_n_ff,
  input wire wr_n_ff,
  input wire bus_rd_valid_ff,
  input wire bus_busy_ff,
  input wire state_clk_ff,
  input wire first_test_pin_out_ff,
  input wire first_test_pin_oe_ff,
  input wire ale_ff,
  input wire [11:0] pc_ff,
  input wire stack_push_ff,
  input wire irq_vector_ff,
  input wire in_service_ff
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);
  reg ret_pend_ff;
  always @(posedge clk_sys) begin
    if (!reset_n) ret_pend_ff <= 1'b0;
    else if (op_return_restore) ret_pend_ff <= 1'b1;
    else if (irq_vector_ff || !in_service_ff) ret_pend_ff <= 1'b0;
  end
  property p_ale_period;
    ale_ff |=> !ale_ff [*8] ##7 ale_ff;
  endproperty
  a_ale_period: assert property (p_ale_period) else $error("address strobe spacing wrong");
  property p_state_period;
    state_clk_ff |=> !state_clk_ff ##1 !state_clk_ff ##1 state_clk_ff;
  endproperty
  a_state_period: assert property (p_state_period) else $error("state tick spacing wrong");
  property p_tclk_out;
    first_test_pin_out_ff == (state_clk_ff && first_test_pin_oe_ff);
  endproperty
  a_tclk_out: assert property (p_tclk_out) else $error("state clock pin output wrong");
  property p_float;
    !bus_busy_ff |-> !bus_oe_ff;
  endproperty
  a_float: assert property (p_float) else $error("bus driven while idle");
  property p_rd_dir;
    !rd_n_ff |-> !bus_oe_ff && wr_n_ff;
  endproperty
  a_rd_dir: assert property (p_rd_dir) else $error("bus driven during read");
  property p_strobe_len;
    $fell(rd_n_ff & wr_n_ff) |=> !(rd_n_ff & wr_n_ff) [*8] ##1 (rd_n_ff & wr_n_ff);
  endproperty
  a_strobe_len: assert property (p_strobe_len) else $error("strobe length wrong");
  property p_wr_hold;
    !wr_n_ff |=> bus_oe_ff && $stable(bus_out_ff);
  endproperty
  a_wr_hold: assert property (p_wr_hold) else $error("write data moved before strobe rise");
  property p_rd_valid;
    $rose(rd_n_ff) |-> bus_rd_valid_ff;
  endproperty
  a_rd_valid: assert property (p_rd_valid) else $error("read data not taken at strobe rise");
  property p_release;
    $rose(rd_n_ff & wr_n_ff) |=> !bus_oe_ff && !bus_busy_ff;
  endproperty
  a_release: assert property (p_release) else $error("bus not released after strobe");
  property p_vector;
    irq_vector_ff |-> stack_push_ff && in_service_ff && (pc_ff == 12'h003 || pc_ff == 12'h007);
  endproperty
  a_vector: assert property (p_vector) else $error("bad interrupt entry");
  property p_one_level;
    irq_vector_ff |-> !$past(in_service_ff) || ret_pend_ff;
  endproperty
  a_one_level: assert property (p_one_level) else $error("nested interrupt accepted");
  c_tmr: cover property (irq_vector_ff && pc_ff == 12'h007);
  c_rd: cover property ($rose(rd_n_ff) && bus_rd_valid_ff);
  c_rechk: cover property (irq_vector_ff && ret_pend_ff);
endmodule
bind tic_ctrl tic_ctrl_asserts u_tic_ctrl_asserts (.clk_sys, .reset_n, .op_return_restore, .bus_out_ff,
  .bus_oe_ff, .rd_n_ff, .wr_n_ff, .bus_rd_valid_ff, .bus_busy_ff, .state_clk_ff, .first_test_pin_out_ff,
  .first_test_pin_oe_ff, .ale_ff, .pc_ff, .stack_push_ff, .irq_vector_ff, .in_service_ff);

/* verification/tic_bus_partner.sv */
// Peripheral model on the strobed data bus
`timescale 1ns/1ns
module tic_bus_partner (
  input wire clk_sys,
  input wire rd_n_ff,
  input wire wr_n_ff,
  input wire bus_oe_ff,
  input wire [7:0] bus_out_ff,
  input wire [7:0] rd_byte,
  output logic [7:0] bus_in,
  output logic [7:0] got_byte
);
  logic [7:0] last_ff = 8'h00;
  always @(posedge clk_sys) begin
    if (!wr_n_ff) got_byte <= bus_out_ff; // Takes data up to strobe rise
    last_ff <= bus_in;
  end
  always_comb begin
    if (bus_oe_ff) bus_in = bus_out_ff;
    else if (!rd_n_ff) bus_in = rd_byte; // Held until read strobe rises
    else bus_in = ~last_ff;
  end
endmodule

/* verification/tic_ctrl_bench.sv */
// Self-checking bench for the cycle, interrupt and timer block
`timescale 1ns/1ns
module tic_ctrl_bench;
  logic clk_sys = 1'b0, reset_n = 1'b0, int_n_pin = 1'b1, ft_pin = 1'b0, cnt_pin = 1'b0;
  logic [7:0] acc_in = 8'h00, rd_byte = 8'h00, v;
  logic [11:0] pc_val = 12'h000;
  logic [15:0] restore_word = 16'h0000;
  logic [19:0] ops = 20'h00000;
  wire [7:0] bus_in, got_byte, bus_out_ff, bus_rd_data_ff, cnt_rd, status_ff;
  wire [11:0] pc_ff;
  wire [15:0] push_data;
  wire bus_oe_ff, rd_n_ff, wr_n_ff, tp_oe, ft_lvl, ci_lvl, int_lvl, ovf_taken, uf1, mb, irq_vec, in_svc;
  int num_errors = 0, cmp_count = 0, cyc = 0;
  tic_ctrl u_tic_ctrl (.clk_sys(clk_sys), .reset_n(reset_n), .int_n_pin(int_n_pin),
    .first_test_pin_in(ft_pin), .count_input_pin(cnt_pin), .bus_in(bus_in), .acc_in(acc_in),
    .op_counter_load(ops[0]), .op_counter_read(ops[1]), .op_branch_on_overflow(ops[2]),
    .op_select_event_counting(ops[3]), .op_select_timer_counting(ops[4]), .op_stop_counter(ops[5]),
    .op_ext_irq_enable(ops[6]), .op_ext_irq_disable(ops[7]), .op_timer_irq_enable(ops[8]),
    .op_timer_irq_disable(ops[9]), .op_state_clock_pin_enable(ops[10]), .op_return_restore(ops[11]),
    .restore_word(restore_word), .op_pc_load(ops[12]), .pc_load_value(pc_val), .op_status_write(ops[13]),
    .status_wr_data(acc_in), .op_user_flag_one_write(ops[14]), .user_flag_one_value(acc_in[0]),
    .op_mem_bank_write(ops[15]), .mem_bank_value(acc_in[1]), .op_bus_static_output(ops[16]),
    .op_bus_static_input(ops[17]), .op_external_data_write(ops[18]), .op_external_data_read(ops[19]),
    .bus_out_ff(bus_out_ff), .bus_oe_ff(bus_oe_ff), .rd_n_ff(rd_n_ff), .wr_n_ff(wr_n_ff),
    .bus_rd_data_ff(bus_rd_data_ff), .bus_rd_valid_ff(), .bus_busy_ff(), .first_test_pin_out_ff(),
    .first_test_pin_oe_ff(tp_oe), .state_clk_ff(), .ale_ff(), .test0_level_ff(ft_lvl),
    .test1_level_ff(ci_lvl), .int_level_ff(int_lvl), .overflow_taken_ff(ovf_taken),
    .counter_rd_data_ff(cnt_rd), .pc_ff(pc_ff), .status_ff(status_ff), .user_flag_one_ff(uf1),
    .mem_bank_ff(mb), .stack_push_ff(), .stack_push_data_ff(push_data), .irq_vector_ff(irq_vec),
    .in_service_ff(in_svc));
  tic_bus_partner u_tic_bus_partner (.clk_sys(clk_sys), .rd_n_ff(rd_n_ff), .wr_n_ff(wr_n_ff),
    .bus_oe_ff(bus_oe_ff), .bus_out_ff(bus_out_ff), .rd_byte(rd_byte), .bus_in(bus_in), .got_byte(got_byte));
  initial forever #2 clk_sys = ~clk_sys;
  task chk(input [15:0] got, input [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task pulse(input [19:0] m);
    @(posedge clk_sys);
    ops <= m;
    @(posedge clk_sys);
    ops <= 20'h00000;
    #1;
  endtask
  task wait_vec;
    int i;
    i = 0;
    while (irq_vec !== 1'b1 && i < 100) begin
      @(posedge clk_sys);
      #1;
      i++;
    end
  endtask
  task tally_and_finish;
    if (num_errors == 0 && cmp_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 8000) begin
      num_errors++;
      tally_and_finish();
    end
  end
  initial begin
    void'($urandom(32'he051));
    repeat (20) @(posedge clk_sys);
    reset_n <= 1'b1;
    for (int k = 0; k < 8; k++) begin
      acc_in <= $urandom;
      rd_byte <= $urandom;
      pulse(20'h10000 << (k % 4));
      repeat (11) @(posedge clk_sys);
      #1;
      if (k % 2 == 0) chk(got_byte, acc_in); // Write data
      else chk(bus_rd_data_ff, rd_byte); // Read data
      chk(bus_oe_ff, 1'b0); // Bus floats
    end
    pc_val <= $urandom;
    acc_in <= {4'($urandom), 4'h0};
    pulse(20'h03000);
    v = acc_in;
    acc_in <= 8'hff;
    pulse(20'h00011);
    int_n_pin <= 1'b0;
    repeat (600) @(posedge clk_sys);
    pulse(20'h00140);
    wait_vec;
    chk(pc_ff, 12'h003); // External first
    chk(push_data, {v[7:4], pc_val}); // Saved context
    int_n_pin <= 1'b1;
    repeat (600) @(posedge clk_sys);
    #1;
    chk({in_svc, pc_ff}, 16'h1003); // Timer held back
    restore_word <= {4'h0, pc_val};
    pulse(20'h00800);
    wait_vec;
    chk(pc_ff, 12'h007); // Recheck after return
    pulse(20'h00004);
    chk(ovf_taken, 1'b1); // Overflow seen
    pulse(20'h00004);
    chk(ovf_taken, 1'b0); // Cleared by
    acc_in <= $urandom;
    pulse(20'h00021);
    pulse(20'h00002);
    chk(cnt_rd, acc_in); // Load and read
    pulse(20'h00a80);
    acc_in <= 8'hfe;
    pulse(20'h00009);
    repeat (4) begin
      cnt_pin <= 1'b1;
      repeat (50) @(posedge clk_sys);
      cnt_pin <= 1'b0;
      repeat (50) @(posedge clk_sys);
    end
    pulse(20'h00022);
    chk(cnt_rd, 8'h02); // Pulses counted
    chk({in_svc, pc_ff}, {1'b0, pc_val}); // Timer request held by disable
    v = $urandom;
    {int_n_pin, ft_pin, cnt_pin} <= v[2:0];
    repeat (5) @(posedge clk_sys);
    #1;
    chk({int_lvl, ft_lvl, ci_lvl}, v[2:0]); // Pin levels
    acc_in <= 8'h03;
    pulse(20'h0c400);
    @(posedge clk_sys);
    #1;
    chk(tp_oe, 1'b1); // State clock on pin
    chk({uf1, mb}, 2'h3); // Flags set before reset
    reset_n <= 1'b0;
    repeat (3) @(posedge clk_sys);
    reset_n <= 1'b1;
    pulse(20'h00002);
    chk(cnt_rd, 8'h02); // Count kept
    chk({pc_ff, uf1, mb, tp_oe, bus_oe_ff}, 16'h0000); // Cleared state
    chk(status_ff, 8'h08); // Cleared status
    tally_and_finish();
  end
endmodule
